//--- hdl/mcf_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - 8-bit mode reads truncated unsigned samples
// - Almost-full when level reaches threshold field, a field of 0 meaning 16
// - Bit 5 gates overrun interrupt
// - Bit 4 gates underrun interrupt
// - Bit 3 gates almost-full DMA request
// - Bit 2 gates almost-full interrupt
// - Bit 1 gates full interrupt
// - Bit 0 enables FIFO, reset disabled
// - Sticky overrun on slot sample when full
// - Sticky underrun on port read when empty
// - Status bit 1 shows live almost-full
// - Status bit 0 shows live full
module mcf_ctrl
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Receive slot 6 samples from the serial audio link
	input  wire logic        slot6_valid_i,
	input  wire logic [15:0] slot6_data_i,
	output logic             slot6_ready_o,
	// System requests
	output logic             irq_o,
	output logic             dma_req_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] thr_decode(input logic [3:0] field);
		thr_decode = (field == 4'h0) ? 5'h10 : {1'b0, field};
	endfunction : thr_decode

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
		reg_hit = (addr == offset);
	endfunction : reg_hit

	function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
		sticky_next = set || (cur && !clr);
	endfunction : sticky_next

	function automatic logic [31:0] port_format(input logic [15:0] smp, input logic mode8);
		if (mode8)
		begin
			port_format = {24'h000000, ~smp[15], smp[14:8]};
		end
		else
		begin
			port_format = {16'h0000, smp};
		end
	endfunction : port_format

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	mcf_pkg::mcf_bus_state_t bus_state_q;
	mcf_pkg::mcf_bus_state_t bus_state_d;

	logic        fifo_en_q;
	logic        full_ie_q;
	logic        afull_ie_q;
	logic        dma_en_q;
	logic        under_ie_q;
	logic        over_ie_q;
	logic [3:0]  thr_q;
	logic        mode8_q;
	logic        over_q;
	logic        under_q;
	logic [31:0] rdata_q;
	logic        wait_q;
	logic        irq_q;
	logic        dma_q;
	logic        ready_q;

	// ----------------------------------------------------------------
	// Sample store
	// ----------------------------------------------------------------
	mcf_fifo_if #(
		.WIDTH   (mcf_pkg::SAMPLE_W),
		.LEVEL_W (mcf_pkg::LEVEL_W)
	) fifo_bus ();

	mcf_fifo #(
		.WIDTH   (mcf_pkg::SAMPLE_W),
		.DEPTH   (mcf_pkg::FIFO_DEPTH),
		.LEVEL_W (mcf_pkg::LEVEL_W)
	) u_fifo (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.f       (fifo_bus.store)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire         req         = avs_read_i || avs_write_i;
	wire         accept      = (bus_state_q == mcf_pkg::BUS_ACK) && req;
	wire         sel_ctrl    = reg_hit(avs_address_i, mcf_pkg::CTRL_OFF);
	wire         sel_stat    = reg_hit(avs_address_i, mcf_pkg::STAT_OFF);
	wire         sel_port    = reg_hit(avs_address_i, mcf_pkg::PORT_OFF);
	wire         wr_ctrl     = accept && avs_write_i && sel_ctrl;
	wire         wr_stat     = accept && avs_write_i && sel_stat;
	wire         rd_port     = accept && avs_read_i && sel_port;
	wire [4:0]   level       = fifo_bus.level;
	wire         is_full     = !fifo_bus.push_ready;
	wire         is_empty    = !fifo_bus.pop_valid;
	wire         is_afull    = (level >= thr_decode(thr_q));
	wire         slot_in     = slot6_valid_i && fifo_en_q;
	wire         over_evt    = slot_in && is_full;
	wire         under_evt   = rd_port && is_empty;
	wire         clr_over    = wr_stat && avs_byteenable_i[0]
	                           && avs_writedata_i[mcf_pkg::STA_OVER];
	wire         clr_under   = wr_stat && avs_byteenable_i[0]
	                           && avs_writedata_i[mcf_pkg::STA_UNDER];

	assign fifo_bus.push_valid = slot_in;
	assign fifo_bus.push_data  = slot6_data_i;
	assign fifo_bus.pop_ready  = rd_port;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [5:0]  ctrl_lo;
	wire [3:0]  stat_lo;
	assign ctrl_lo[mcf_pkg::CTL_EN_BIT]   = fifo_en_q;
	assign ctrl_lo[mcf_pkg::CTL_FULL_IE]  = full_ie_q;
	assign ctrl_lo[mcf_pkg::CTL_AFULL_IE] = afull_ie_q;
	assign ctrl_lo[mcf_pkg::CTL_DMA_EN]   = dma_en_q;
	assign ctrl_lo[mcf_pkg::CTL_UNDER_IE] = under_ie_q;
	assign ctrl_lo[mcf_pkg::CTL_OVER_IE]  = over_ie_q;
	assign stat_lo[mcf_pkg::STA_FULL]     = is_full;
	assign stat_lo[mcf_pkg::STA_AFULL]    = is_afull;
	assign stat_lo[mcf_pkg::STA_UNDER]    = under_q;
	assign stat_lo[mcf_pkg::STA_OVER]     = over_q;
	wire [31:0] ctrl_word = {19'h00000, mode8_q, thr_q, 2'b00, ctrl_lo};
	wire [31:0] stat_word = {28'h0000000, stat_lo};
	wire [31:0] port_word = is_empty ? 32'h00000000
	                                 : port_format(fifo_bus.pop_data, mode8_q);
	wire [31:0] rd_mux    = sel_ctrl ? ctrl_word :
	                        sel_stat ? stat_word :
	                        sel_port ? port_word : 32'h00000000;

	// ----------------------------------------------------------------
	// Bus handshake: one wait cycle, then accept
	// ----------------------------------------------------------------
	always_comb
	begin
		bus_state_d = bus_state_q;
		unique case (bus_state_q)
			mcf_pkg::BUS_IDLE:
			begin
				if (req)
				begin
					bus_state_d = mcf_pkg::BUS_ACK;
				end
			end
			mcf_pkg::BUS_ACK:
			begin
				bus_state_d = mcf_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bus_state_q <= mcf_pkg::BUS_IDLE;
		end
		else
		begin
			bus_state_q <= bus_state_d;
		end
	end

	// ----------------------------------------------------------------
	// Wait and read data
	// ----------------------------------------------------------------
	wire         bus_start   = (bus_state_q == mcf_pkg::BUS_IDLE) && req;
	wire         rd_take     = (bus_state_q == mcf_pkg::BUS_IDLE) && avs_read_i;
	wire         wait_d      = !bus_start;
	wire [31:0]  rdata_d     = rd_take ? rd_mux : rdata_q;

	// Low only in the cycle before the accepting edge
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wait_q <= 1'b1;
		end
		else
		begin
			wait_q <= wait_d;
		end
	end

	// Snapshot stands until the next read
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q <= 32'h00000000;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	wire         wr_ctrl_lo  = wr_ctrl && avs_byteenable_i[0];
	wire         wr_ctrl_hi  = wr_ctrl && avs_byteenable_i[1];

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{over_ie_q, under_ie_q, dma_en_q,
			 afull_ie_q, full_ie_q, fifo_en_q} <= mcf_pkg::CTL_IE_RST;
		end
		else if (wr_ctrl_lo)
		begin
			fifo_en_q  <= avs_writedata_i[mcf_pkg::CTL_EN_BIT];
			full_ie_q  <= avs_writedata_i[mcf_pkg::CTL_FULL_IE];
			afull_ie_q <= avs_writedata_i[mcf_pkg::CTL_AFULL_IE];
			dma_en_q   <= avs_writedata_i[mcf_pkg::CTL_DMA_EN];
			under_ie_q <= avs_writedata_i[mcf_pkg::CTL_UNDER_IE];
			over_ie_q  <= avs_writedata_i[mcf_pkg::CTL_OVER_IE];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			thr_q   <= mcf_pkg::THR_RST;
			mode8_q <= mcf_pkg::MODE8_RST;
		end
		else if (wr_ctrl_hi)
		begin
			thr_q   <= avs_writedata_i[mcf_pkg::CTL_THR_LSB +: 4];
			mode8_q <= avs_writedata_i[mcf_pkg::CTL_8BIT];
		end
	end

	// ----------------------------------------------------------------
	// Sticky errors, set beats clear
	// ----------------------------------------------------------------
	wire         over_d      = sticky_next(over_q, over_evt, clr_over);
	wire         under_d     = sticky_next(under_q, under_evt, clr_under);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			over_q <= 1'b0;
		end
		else
		begin
			over_q <= over_d;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			under_q <= 1'b0;
		end
		else
		begin
			under_q <= under_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and DMA requests
	// ----------------------------------------------------------------
	wire         irq_full    = is_full && full_ie_q;
	wire         irq_afull   = is_afull && afull_ie_q;
	wire         irq_over    = over_q && over_ie_q;
	wire         irq_under   = under_q && under_ie_q;
	wire         irq_d       = irq_full || irq_afull || irq_over || irq_under;
	wire         dma_d       = fifo_en_q && dma_en_q && is_afull;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dma_q <= 1'b0;
		end
		else
		begin
			dma_q <= dma_d;
		end
	end

	// ----------------------------------------------------------------
	// Link ready
	// ----------------------------------------------------------------
	wire         ready_d     = fifo_en_q && !is_full;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ready_q <= 1'b0;
		end
		else
		begin
			ready_q <= ready_d;
		end
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign slot6_ready_o     = ready_q;
	assign irq_o             = irq_q;
	assign dma_req_o         = dma_q;

endmodule : mcf_ctrl

//--- common/mcf_pkg.sv
package mcf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W        = 8;
	localparam logic [7:0]  CTRL_OFF      = 8'h30;
	localparam logic [7:0]  STAT_OFF      = 8'h34;
	localparam logic [7:0]  PORT_OFF      = 8'h38;

	// ----------------------------------------------------------------
	// Control field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTL_EN_BIT    = 0;
	localparam int unsigned CTL_FULL_IE   = 1;
	localparam int unsigned CTL_AFULL_IE  = 2;
	localparam int unsigned CTL_DMA_EN    = 3;
	localparam int unsigned CTL_UNDER_IE  = 4;
	localparam int unsigned CTL_OVER_IE   = 5;
	localparam int unsigned CTL_THR_LSB   = 8;
	localparam int unsigned CTL_8BIT      = 12;
	localparam logic [5:0]  CTL_IE_RST    = 6'h00;
	localparam logic [3:0]  THR_RST       = 4'h8;
	localparam logic        MODE8_RST     = 1'b0;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int unsigned STA_FULL      = 0;
	localparam int unsigned STA_AFULL     = 1;
	localparam int unsigned STA_UNDER     = 2;
	localparam int unsigned STA_OVER      = 3;

	// ----------------------------------------------------------------
	// Storage shape
	// ----------------------------------------------------------------
	localparam int unsigned SAMPLE_W      = 16;
	localparam int unsigned FIFO_DEPTH    = 16;
	localparam int unsigned LEVEL_W       = 5;

	typedef enum logic [0:0]
	{
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} mcf_bus_state_t;

endpackage : mcf_pkg

//--- common/mcf_fifo_if.sv
`timescale 1ns/1ps
interface mcf_fifo_if #(
	parameter int unsigned WIDTH   = 16,
	parameter int unsigned LEVEL_W = 5
);
	logic               push_valid;
	logic               push_ready;
	logic [WIDTH-1:0]   push_data;
	logic               pop_valid;
	logic               pop_ready;
	logic [WIDTH-1:0]   pop_data;
	logic [LEVEL_W-1:0] level;

	modport store
	(
		input  push_valid,
		output push_ready,
		input  push_data,
		output pop_valid,
		input  pop_ready,
		output pop_data,
		output level
	);

	modport user
	(
		output push_valid,
		input  push_ready,
		output push_data,
		input  pop_valid,
		output pop_ready,
		input  pop_data,
		input  level
	);

endinterface : mcf_fifo_if

//--- hdl/mcf_fifo.sv
`timescale 1ns/1ps
module mcf_fifo #(
	parameter int unsigned WIDTH   = 16,
	parameter int unsigned DEPTH   = 16,
	parameter int unsigned LEVEL_W = 5
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Both sides
	mcf_fifo_if.store f
);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0]   mem_q [DEPTH];
	logic [PTR_W-1:0]   wr_ptr_q;
	logic [PTR_W-1:0]   rd_ptr_q;
	logic [LEVEL_W-1:0] level_q;
	wire                do_push;
	wire                do_pop;

	assign f.push_ready = (level_q != LEVEL_W'(DEPTH));
	assign f.pop_valid  = (level_q != '0);
	assign f.pop_data   = mem_q[rd_ptr_q];
	assign f.level      = level_q;
	assign do_push      = f.push_valid && f.push_ready;
	assign do_pop       = f.pop_ready && f.pop_valid;

	always_ff @(posedge clk_i)
	begin
		if (do_push)
		begin
			mem_q[wr_ptr_q] <= f.push_data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q  <= '0;
		end
		else
		begin
			if (do_push)
			begin
				wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
			end
			if (do_pop)
			begin
				rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
			end
			if (do_push && !do_pop)
			begin
				level_q <= LEVEL_W'(level_q + 1'b1);
			end
			else if (do_pop && !do_push)
			begin
				level_q <= LEVEL_W'(level_q - 1'b1);
			end
		end
	end

endmodule : mcf_fifo

//--- dv/mcf_codec_model.sv
`timescale 1ns/1ps
module mcf_codec_model
(
	// Clock
	input  wire logic   clk_i,
	// Slot 6 stream
	output logic        valid_o,
	output logic [15:0] data_o
);
	initial
	begin
		valid_o = 1'b0;
		data_o  = 16'h0000;
	end
	// Idle data shows the inverse, never a stale sample
	task automatic send(input logic [15:0] d, input int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		valid_o <= 1'b1;
		data_o  <= d;
		@(posedge clk_i);
		valid_o <= 1'b0;
		data_o  <= ~d;
	endtask : send
endmodule : mcf_codec_model

//--- dv/mcf_ctrl_props.sv
`timescale 1ns/1ps
module mcf_ctrl_props
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// Bus
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// Slot and requests
	input wire logic        slot6_valid_i,
	input wire logic [15:0] slot6_data_i,
	input wire logic        slot6_ready_o,
	input wire logic        irq_o,
	input wire logic        dma_req_o
);
	// ----
	// Shadow of the control register
	// ----
	logic [12:0] ctl_q;
	logic [12:0] ctl_d;
	wire         acc     = !avs_waitrequest_o;
	wire         ctl_wr  = acc && avs_write_i && avs_address_i == mcf_pkg::CTRL_OFF;
	wire         rd_stat = acc && avs_read_i && avs_address_i == mcf_pkg::STAT_OFF;
	wire         rd_port = acc && avs_read_i && avs_address_i == mcf_pkg::PORT_OFF;
	wire         any_ie  = ctl_q[1] | ctl_q[2] | ctl_q[4] | ctl_q[5];
	assign ctl_d[7:0]  = (ctl_wr && avs_byteenable_i[0]) ? {2'h0, avs_writedata_i[5:0]} : ctl_q[7:0];
	assign ctl_d[12:8] = (ctl_wr && avs_byteenable_i[1]) ? avs_writedata_i[12:8] : ctl_q[12:8];
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			ctl_q <= 13'h0800;
		else
			ctl_q <= ctl_d;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_wait_one; $fell(avs_waitrequest_o) |=> avs_waitrequest_o; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low too long");
	property p_stat_rsvd; rd_stat |-> avs_readdata_o[31:4] == 28'h0000000; endproperty
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status upper bits");
	property p_port8; rd_port && ctl_q[12] |-> avs_readdata_o[31:8] == 24'h000000; endproperty
	a_port8: assert property (p_port8) else $error("8-bit read too wide");
	property p_port16; rd_port |-> avs_readdata_o[31:16] == 16'h0000; endproperty
	a_port16: assert property (p_port16) else $error("16-bit read too wide");
	property p_dma_gate; dma_req_o |-> $past(ctl_q[3]); endproperty
	a_dma_gate: assert property (p_dma_gate) else $error("dma without enable");
	property p_dma_off; dma_req_o |-> $past(ctl_q[0]); endproperty
	a_dma_off: assert property (p_dma_off) else $error("dma while disabled");
	property p_irq_gate; irq_o |-> $past(any_ie); endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
	property p_ready_en; slot6_ready_o |-> $past(ctl_q[0]); endproperty
	a_ready_en: assert property (p_ready_en) else $error("ready while disabled");
endmodule : mcf_ctrl_props

bind mcf_ctrl mcf_ctrl_props i_props
(
	.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .slot6_valid_i(slot6_valid_i),
	.slot6_data_i(slot6_data_i), .slot6_ready_o(slot6_ready_o), .irq_o(irq_o),
	.dma_req_o(dma_req_o)
);

//--- dv/mcf_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_tests++; \
		if ((a) !== (b)) \
		begin \
			errors++; \
			$display("[ERR] %0t %h %h", $time, (a), (b)); \
		end \
	end
module mcf_ctrl_tb;
	localparam logic [7:0] CT = mcf_pkg::CTRL_OFF;
	localparam logic [7:0] ST = mcf_pkg::STAT_OFF;
	localparam logic [7:0] PT = mcf_pkg::PORT_OFF;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        slot6_valid_i;
	logic [15:0] slot6_data_i;
	logic        slot6_ready_o;
	logic        irq_o;
	logic        dma_req_o;
	logic [31:0] q;
	logic [15:0] cnt = 16'h0000;
	int          errors = 0;
	int          n_tests = 0;
	always #4 clk_i = ~clk_i;
	mcf_ctrl i_dut
	(
		.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .slot6_valid_i(slot6_valid_i),
		.slot6_data_i(slot6_data_i), .slot6_ready_o(slot6_ready_o), .irq_o(irq_o),
		.dma_req_o(dma_req_o)
	);
	mcf_codec_model i_codec (.clk_i(clk_i), .valid_o(slot6_valid_i), .data_o(slot6_data_i));
	// ----
	// Bus and stream helpers
	// ----
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i   <= a;
		avs_read_i      <= !wr;
		avs_write_i     <= wr;
		avs_writedata_i <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		`CHK(q, e)
	endtask : rd
	task automatic push(input int n);
		repeat (n)
		begin
			i_codec.send(16'h5A00 + cnt, cnt % 3);
			cnt++;
		end
	endtask : push
	task automatic idle;
		repeat (3) @(posedge clk_i);
	endtask : idle
	// ----
	// Scenarios
	// ----
	task automatic t_off;
		`CHK(slot6_ready_o, 1'b0)
		rd(CT, 32'h00000800);
		rd(ST, 32'h00000000);
		rd(8'h3C, 32'h00000000);
		i_codec.send(16'h1111, 0);
		rd(PT, 32'h00000000);
		rd(ST, 32'h00000004);
		bus(1'b1, ST, 32'h00000000);
		rd(ST, 32'h00000004);
		bus(1'b1, ST, 32'h00000004);
		rd(ST, 32'h00000000);
		$display("t_off done");
	endtask : t_off
	task automatic t_fill;
		int i;
		bus(1'b1, CT, 32'h00000809);
		push(7);
		rd(ST, 32'h00000000);
		`CHK(dma_req_o, 1'b0)
		push(1);
		rd(ST, 32'h00000002);
		`CHK(slot6_ready_o, 1'b1)
		`CHK(dma_req_o, 1'b1)
		`CHK(irq_o, 1'b0)
		push(8);
		rd(ST, 32'h00000003);
		`CHK(slot6_ready_o, 1'b0)
		push(1);
		rd(ST, 32'h0000000B);
		bus(1'b1, CT, 32'h00000808);
		idle;
		`CHK(dma_req_o, 1'b0)
		for (i = 0; i < 3; i++)
		begin
			bus(1'b1, CT, (i == 0) ? 32'h00000821 : (i == 1) ? 32'h00000803 : 32'h00000805);
			idle;
			`CHK(irq_o, 1'b1)
		end
		bus(1'b1, CT, 32'h00000821);
		bus(1'b1, ST, 32'h00000008);
		rd(ST, 32'h00000003);
		`CHK(irq_o, 1'b0)
		for (i = 0; i < 16; i++)
			rd(PT, 32'h00005A00 + i);
		rd(ST, 32'h00000000);
		$display("t_fill done");
	endtask : t_fill
	task automatic t_mode8;
		bus(1'b1, CT, 32'h00001111);
		i_codec.send(16'h1234, 0);
		rd(ST, 32'h00000002);
		rd(PT, 32'h00000092);
		i_codec.send(16'h8A55, 1);
		rd(PT, 32'h0000000A);
		`CHK(irq_o, 1'b0)
		rd(PT, 32'h00000000);
		idle;
		`CHK(irq_o, 1'b1)
		bus(1'b1, ST, 32'h00000004);
		idle;
		`CHK(irq_o, 1'b0)
		$display("t_mode8 done");
	endtask : t_mode8
	task automatic conclude;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_off;
		t_fill;
		t_mode8;
		conclude;
	end
	initial
	begin
		#100000;
		errors++;
		conclude;
	end
endmodule : mcf_ctrl_tb
